// [hw/pqd_pkg.sv]
`default_nettype none
package pqd_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] PQD_A_CTRL = 8'h00;
   localparam logic [7:0] PQD_A_STATUS = 8'h04;
   localparam logic [7:0] PQD_A_PORT = 8'h08;
   localparam logic [7:0] PQD_A_MSG = 8'h0C;
   localparam logic [7:0] PQD_A_DPORT = 8'h10;
   localparam logic [7:0] PQD_A_CUR = 8'h14;
   localparam logic [7:0] PQD_A_RESULT = 8'h18;
   localparam logic [31:0] PQD_RST_WORD = 32'h0000_0000;
   // ----------------------------------------
   // data structure layout (word offsets, bits)
   // ----------------------------------------
   localparam int PQD_LOCK_BIT = 0;
   localparam int PQD_TYPE_BIT = 16;
   localparam int PQD_QSTATE_BIT = 17;
   localparam int PQD_NUM_PRIO = 32;
   localparam logic [31:0] PQD_STAT_OFS = 32'h0000_0001;
   localparam logic [31:0] PQD_FHEAD_OFS = 32'h0000_0001;
   localparam logic [31:0] PQD_PHDR_OFS = 32'h0000_0002;
   localparam logic [31:0] PQD_LINK_OFS = 32'h0000_0000;
   localparam logic [31:0] PQD_CURP_OFS = 32'h0000_0001;
   localparam logic [31:0] PQD_PRIO_OFS = 32'h0000_0002;
   localparam logic [31:0] PQD_DPORT_OFS = 32'h0000_0003;
   // ----------------------------------------
   // commands and engine states
   // ----------------------------------------
   typedef enum logic [2:0] {
      PQD_OP_NONE = 3'b000,
      PQD_OP_SCHED = 3'b001,
      PQD_OP_SEND = 3'b010,
      PQD_OP_RECV = 3'b011,
      PQD_OP_DISP = 3'b100
   } pqd_op_e;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_RD_PRIO = 4'b0001,
      S_RD_DPORT = 4'b0010,
      S_LOCK = 4'b0011,
      S_RD_STAT = 4'b0100,
      S_RD_HEAD = 4'b0101,
      S_RD_TAIL = 4'b0110,
      S_RD_NEXT = 4'b0111,
      S_W_TLINK = 4'b1000,
      S_W_MLINK = 4'b1001,
      S_W_MCUR = 4'b1010,
      S_W_HEAD = 4'b1011,
      S_W_TAIL = 4'b1100,
      S_W_STAT = 4'b1101,
      S_UNLOCK = 4'b1110
   } pqd_st_e;
   // memory request carrier
   typedef struct packed {
      logic we;
      logic tas;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pqd_mreq_s;
endpackage
`default_nettype wire

// [hw/pqd_prio_enc.sv]
`timescale 1ns/100ps
`default_nettype none
module pqd_prio_enc
   import pqd_pkg::*;
(
   // status bits in
   input wire logic [PQD_NUM_PRIO-1:0] bits,
   // highest set index out
   output logic [4:0] idx
);
   // later (higher) bits override lower ones
   always_comb begin
      idx = 5'h00;
      for (int i = 0; i < PQD_NUM_PRIO; i++) begin
         if (bits[i]) begin
            idx = 5'(i);
         end
      end
   end
endmodule
`default_nettype wire

// [hw/pqd_top.sv]
`timescale 1ns/100ps
`default_nettype none
module pqd_top
   import pqd_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // shared memory master
   output logic mem_req,
   output logic mem_we,
   output logic mem_tas,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   // engine state
   output logic busy,
   output logic [31:0] cur_pcb
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   pqd_st_e st_q;
   pqd_op_e op_q;
   pqd_mreq_s mreq, mreq_q;
   logic [31:0] port_sel_q, msg_sel_q, dport_q, cur_q, result_q;
   logic [31:0] port_q, msg_q, w0_q, stat_q, head_q, rd_q, hq;
   logic [31:0] prdata_q;
   logic [4:0] prio_q, enc_idx, qidx;
   logic busy_q, empty_q, done_q, enq_q, at_head_q, phase2_q;
   logic req_q, ack_q, pready_q, pslverr_q, is_prio, ins_head;
   logic mem_go, apb_wr, start;

   // decode of mapped register offsets
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == PQD_A_CTRL) || (a == PQD_A_STATUS) ||
         (a == PQD_A_PORT) || (a == PQD_A_MSG) || (a == PQD_A_DPORT) ||
         (a == PQD_A_CUR) || (a == PQD_A_RESULT);
   endfunction

   // ----------------------------------------
   // apb slave, one wait state per access
   // ----------------------------------------
   assign apb_wr = psel & penable & pwrite & pready_q;
   assign start = apb_wr && (paddr == PQD_A_CTRL) && !busy_q &&
      (pwdata[2:0] != PQD_OP_NONE) && (pwdata[2:0] <= PQD_OP_DISP);

   // ready, error and read data registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= PQD_RST_WORD;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~reg_hit(paddr);
         prdata_q <= PQD_RST_WORD;
         if (psel && penable && !pready_q && !pwrite) begin
            case (paddr)
               PQD_A_CTRL: prdata_q <= {29'h0, op_q};
               PQD_A_STATUS: prdata_q <= {29'h0, done_q, empty_q, busy_q};
               PQD_A_PORT: prdata_q <= port_sel_q;
               PQD_A_MSG: prdata_q <= msg_sel_q;
               PQD_A_DPORT: prdata_q <= dport_q;
               PQD_A_CUR: prdata_q <= cur_q;
               PQD_A_RESULT: prdata_q <= result_q;
               default: prdata_q <= PQD_RST_WORD;
            endcase
         end
      end
   end

   // software operand registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_sel_q <= PQD_RST_WORD;
         msg_sel_q <= PQD_RST_WORD;
         dport_q <= PQD_RST_WORD;
      end else if (apb_wr) begin
         if (paddr == PQD_A_PORT) port_sel_q <= pwdata;
         if (paddr == PQD_A_MSG) msg_sel_q <= pwdata;
         if (paddr == PQD_A_DPORT) dport_q <= pwdata;
      end
   end

   // ----------------------------------------
   // queue addressing
   // ----------------------------------------
   pqd_prio_enc u_enc (
      .bits(stat_q),
      .idx(enc_idx)
   );

   assign is_prio = w0_q[PQD_TYPE_BIT];
   assign qidx = enq_q ? prio_q : enc_idx;
   assign ins_head = at_head_q || (head_q == PQD_RST_WORD);
   // header pair per priority, single header for fifo
   assign hq = is_prio ? port_q + PQD_PHDR_OFS + {26'h0, qidx, 1'b0} :
      port_q + PQD_FHEAD_OFS;

   // ----------------------------------------
   // memory request per state
   // ----------------------------------------
   always_comb begin
      mreq = '0;
      case (st_q)
         S_RD_PRIO: mreq.addr = msg_q + PQD_PRIO_OFS;
         S_RD_DPORT: mreq.addr = msg_q + PQD_DPORT_OFS;
         S_LOCK: begin
            mreq.addr = port_q;
            mreq.tas = 1'b1;
         end
         S_RD_STAT: mreq.addr = port_q + PQD_STAT_OFS;
         S_RD_HEAD: mreq.addr = hq;
         S_RD_TAIL: mreq.addr = hq + 32'h1;
         S_RD_NEXT: mreq.addr = head_q + PQD_LINK_OFS;
         S_W_TLINK: begin
            mreq.we = 1'b1;
            mreq.addr = rd_q + PQD_LINK_OFS;
            mreq.wdata = msg_q;
         end
         S_W_MLINK: begin
            mreq.we = 1'b1;
            mreq.addr = msg_q + PQD_LINK_OFS;
            mreq.wdata = ins_head ? head_q : PQD_RST_WORD;
         end
         S_W_MCUR: begin
            mreq.we = 1'b1;
            mreq.addr = msg_q + PQD_CURP_OFS;
            mreq.wdata = enq_q ? port_q : PQD_RST_WORD;
         end
         S_W_HEAD: begin
            mreq.we = 1'b1;
            mreq.addr = hq;
            mreq.wdata = enq_q ? msg_q : rd_q;
         end
         S_W_TAIL: begin
            mreq.we = 1'b1;
            mreq.addr = hq + 32'h1;
            mreq.wdata = enq_q ? msg_q : PQD_RST_WORD;
         end
         S_W_STAT: begin
            mreq.we = 1'b1;
            mreq.addr = port_q + PQD_STAT_OFS;
            mreq.wdata = enq_q ? (stat_q | (32'h1 << qidx)) :
               (stat_q & ~(32'h1 << qidx));
         end
         S_UNLOCK: begin
            mreq.we = 1'b1;
            mreq.addr = port_q;
            mreq.wdata = w0_q & ~(32'h1 << PQD_LOCK_BIT);
         end
         default: mreq = '0;
      endcase
   end

   assign mem_go = (st_q != S_IDLE) && !req_q && !ack_q;

   // request held until acknowledged, read data captured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 1'b0;
         ack_q <= 1'b0;
         mreq_q <= '0;
         rd_q <= PQD_RST_WORD;
      end else begin
         ack_q <= 1'b0;
         if (mem_go) begin
            req_q <= 1'b1;
            mreq_q <= mreq;
         end else if (req_q && mem_ack) begin
            req_q <= 1'b0;
            ack_q <= 1'b1;
            if (!mreq_q.we) rd_q <= mem_rdata;
         end
      end
   end

   // ----------------------------------------
   // sequencing engine
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= S_IDLE;
         op_q <= PQD_OP_NONE;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         empty_q <= 1'b0;
         enq_q <= 1'b0;
         at_head_q <= 1'b0;
         phase2_q <= 1'b0;
         port_q <= PQD_RST_WORD;
         msg_q <= PQD_RST_WORD;
         w0_q <= PQD_RST_WORD;
         stat_q <= PQD_RST_WORD;
         head_q <= PQD_RST_WORD;
         prio_q <= 5'h00;
         result_q <= PQD_RST_WORD;
         cur_q <= PQD_RST_WORD;
      end else if (st_q == S_IDLE) begin
         if (apb_wr && paddr == PQD_A_CUR && !busy_q) cur_q <= pwdata;
         if (start) begin
            op_q <= pqd_op_e'(pwdata[2:0]);
            busy_q <= 1'b1;
            done_q <= 1'b0;
            empty_q <= 1'b0;
            phase2_q <= 1'b0;
            enq_q <= 1'b1;
            at_head_q <= (pwdata[2:0] == PQD_OP_SCHED);
            msg_q <= msg_sel_q;
            port_q <= port_sel_q;
            stat_q <= PQD_RST_WORD;
            st_q <= S_RD_PRIO;
            case (pwdata[2:0])
               PQD_OP_RECV: begin
                  enq_q <= 1'b0;
                  st_q <= S_LOCK;
               end
               PQD_OP_DISP: begin
                  msg_q <= cur_q;
                  if (cur_q == PQD_RST_WORD) begin
                     phase2_q <= 1'b1;
                     enq_q <= 1'b0;
                     port_q <= dport_q;
                     st_q <= S_LOCK;
                  end
               end
               default: st_q <= S_RD_PRIO;
            endcase
         end
      end else if (ack_q) begin
         case (st_q)
            S_RD_PRIO: begin
               prio_q <= rd_q[4:0];
               st_q <= (op_q == PQD_OP_SEND) ? S_LOCK : S_RD_DPORT;
            end
            S_RD_DPORT: begin
               port_q <= rd_q;
               st_q <= S_LOCK;
            end
            S_LOCK: begin
               if (!rd_q[PQD_LOCK_BIT]) begin
                  w0_q <= rd_q;
                  st_q <= rd_q[PQD_TYPE_BIT] ? S_RD_STAT : S_RD_HEAD;
               end
            end
            S_RD_STAT: begin
               stat_q <= rd_q;
               if (!enq_q && rd_q == PQD_RST_WORD) begin
                  empty_q <= 1'b1;
                  st_q <= S_UNLOCK;
               end else begin
                  st_q <= S_RD_HEAD;
               end
            end
            S_RD_HEAD: begin
               head_q <= rd_q;
               if (enq_q) begin
                  st_q <= (at_head_q || rd_q == PQD_RST_WORD) ? S_W_MLINK : S_RD_TAIL;
               end else if (rd_q == PQD_RST_WORD) begin
                  empty_q <= 1'b1;
                  st_q <= S_UNLOCK;
               end else begin
                  msg_q <= rd_q;
                  st_q <= S_RD_NEXT;
               end
            end
            S_RD_TAIL: st_q <= S_W_TLINK;
            S_RD_NEXT: st_q <= S_W_HEAD;
            S_W_TLINK: st_q <= S_W_MLINK;
            S_W_MLINK: st_q <= S_W_MCUR;
            S_W_MCUR: begin
               if (!enq_q) st_q <= S_UNLOCK;
               else st_q <= ins_head ? S_W_HEAD : S_W_TAIL;
            end
            S_W_HEAD: begin
               if (enq_q) st_q <= (head_q == PQD_RST_WORD) ? S_W_TAIL : S_UNLOCK;
               else st_q <= (rd_q == PQD_RST_WORD) ? S_W_TAIL : S_W_MCUR;
            end
            S_W_TAIL: begin
               if (enq_q) begin
                  st_q <= (head_q == PQD_RST_WORD && is_prio) ? S_W_STAT : S_UNLOCK;
               end else begin
                  st_q <= is_prio ? S_W_STAT : S_W_MCUR;
               end
            end
            S_W_STAT: begin
               stat_q <= mreq_q.wdata;
               st_q <= enq_q ? S_UNLOCK : S_W_MCUR;
            end
            S_UNLOCK: begin
               if (op_q == PQD_OP_DISP && !phase2_q) begin
                  phase2_q <= 1'b1;
                  enq_q <= 1'b0;
                  port_q <= dport_q;
                  stat_q <= PQD_RST_WORD;
                  st_q <= S_LOCK;
               end else begin
                  if (!enq_q) result_q <= empty_q ? PQD_RST_WORD : msg_q;
                  if (op_q == PQD_OP_DISP) begin
                     cur_q <= empty_q ? PQD_RST_WORD : msg_q;
                  end
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign mem_req = req_q;
   assign mem_we = mreq_q.we;
   assign mem_tas = mreq_q.tas;
   assign mem_addr = mreq_q.addr;
   assign mem_wdata = mreq_q.wdata;
   assign busy = busy_q;
   assign cur_pcb = cur_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_lock_spin: assert property (
      st_q == S_LOCK && ack_q && rd_q[0] |=> st_q == S_LOCK ##2 mem_req && mem_tas)
      else $error("lock not retried while held");
   chk_type_sel: assert property (
      st_q == S_LOCK && ack_q && !rd_q[0] |=>
      st_q == ($past(rd_q[16]) ? S_RD_STAT : S_RD_HEAD))
      else $error("port type not taken from bit 16");
   chk_unlock_clr: assert property (
      mem_req && st_q == S_UNLOCK |-> mem_we && !mem_wdata[0] && mem_addr == port_q)
      else $error("unlock does not clear lock bit");
   chk_empty_head: assert property (
      st_q == S_RD_HEAD && ack_q && !enq_q && rd_q == 32'h0 |=>
      st_q == S_UNLOCK && empty_q)
      else $error("zero head not treated as empty");
   chk_prio_pick: assert property (
      st_q == S_RD_HEAD && !enq_q && is_prio && stat_q != 32'h0 |->
      (stat_q >> qidx) == 32'h1)
      else $error("not highest non-empty queue");
   chk_stat_set: assert property (
      mem_req && st_q == S_W_STAT |-> mem_wdata[qidx] == enq_q)
      else $error("status bit inconsistent with queue");
   chk_head_ins: assert property (
      mem_req && st_q == S_W_HEAD && enq_q |-> mem_wdata == msg_q && mem_addr == hq)
      else $error("head insert wrong");
   chk_tail_link: assert property (
      mem_req && st_q == S_W_TLINK |-> mem_wdata == msg_q && !mem_tas)
      else $error("tail link not set to new message");
endmodule
`default_nettype wire

// [testbench/pqd_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pqd_mem_model (
   // clock
   input wire logic pclk,
   // request from the engine
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_tas,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   // answer and latency knob
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   input wire logic [3:0] lat
);
   logic [31:0] mem [0:255];
   logic [3:0] cnt;
   // messages and ports start as all-zero words
   initial begin
      foreach (mem[i]) begin
         mem[i] = 32'h0;
      end
      cnt = 4'h0;
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
   end
   // answer one request after lat idle cycles, garbage data between answers
   always @(posedge pclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         if (cnt < lat) begin
            cnt <= cnt + 4'h1;
         end else begin
            cnt <= 4'h0;
            mem_ack <= 1'b1;
            if (mem_we) begin
               mem[mem_addr[7:0]] <= mem_wdata;
            end else begin
               mem_rdata <= mem[mem_addr[7:0]];
            end
            // old word returned, lock bit set in one step
            if (mem_tas) begin
               mem[mem_addr[7:0]] <= mem[mem_addr[7:0]] | 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/port_queue_dispatcher_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module port_queue_dispatcher_bench
   import pqd_pkg::*;
;
   typedef struct packed {
      pqd_op_e op;
      logic [7:0] port;
      logic [7:0] msg;
      logic [7:0] res;
      logic [31:0] w1;
   } pqd_row_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, cur_pcb, rdat;
   logic pready, pslverr, mem_req, mem_we, mem_tas, mem_ack, busy, serr, e_empty;
   logic [3:0] lat = 4'h0;
   int comparisons = 0;
   int n_fail = 0;
   int k;
   pqd_row_s rows [18];
   // ----------------------------------------
   // design, memory and clock
   // ----------------------------------------
   pqd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_tas(mem_tas),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .busy(busy), .cur_pcb(cur_pcb));
   pqd_mem_model i_mem (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we),
      .mem_tas(mem_tas), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .lat(lat));
   always #25 pclk = ~pclk;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task give_verdict;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one apb transfer, held until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            break;
         end
      end
      if (i == 20) begin
         n_fail++;
         give_verdict();
      end
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_idle;
      int i;
      repeat (2) @(posedge pclk);
      for (i = 0; i < 600; i++) begin
         @(posedge pclk);
         #1;
         if (busy === 1'b0) begin
            break;
         end
      end
      if (i == 600) begin
         n_fail++;
         give_verdict();
      end
   endtask
   task start(input pqd_op_e op, input logic [7:0] port, input logic [7:0] msg);
      apb(1'b1, PQD_A_PORT, {24'h0, port});
      apb(1'b1, PQD_A_DPORT, {24'h0, port});
      apb(1'b1, PQD_A_MSG, {24'h0, msg});
      apb(1'b1, PQD_A_CTRL, {29'h0, op});
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rows[0] = '{PQD_OP_SEND, 8'h10, 8'hA0, 8'h00, 32'h0000_00A0};
      rows[1] = '{PQD_OP_SEND, 8'h10, 8'hA4, 8'h00, 32'h0000_00A0};
      rows[2] = '{PQD_OP_RECV, 8'h10, 8'h00, 8'hA0, 32'h0000_00A4};
      rows[3] = '{PQD_OP_RECV, 8'h10, 8'h00, 8'hA4, 32'h0000_0000};
      rows[4] = '{PQD_OP_RECV, 8'h10, 8'h00, 8'h00, 32'h0000_0000};
      rows[5] = '{PQD_OP_SEND, 8'h40, 8'hA8, 8'h00, 32'h0000_0008};
      rows[6] = '{PQD_OP_SEND, 8'h40, 8'hAC, 8'h00, 32'h0010_0008};
      rows[7] = '{PQD_OP_SEND, 8'h40, 8'hB0, 8'h00, 32'h0010_0008};
      rows[8] = '{PQD_OP_SEND, 8'h40, 8'hB4, 8'h00, 32'h8010_0008};
      rows[9] = '{PQD_OP_RECV, 8'h40, 8'h00, 8'hB4, 32'h0010_0008};
      rows[10] = '{PQD_OP_RECV, 8'h40, 8'h00, 8'hAC, 32'h0010_0008};
      rows[11] = '{PQD_OP_RECV, 8'h40, 8'h00, 8'hB0, 32'h0000_0008};
      rows[12] = '{PQD_OP_RECV, 8'h40, 8'h00, 8'hA8, 32'h0000_0000};
      rows[13] = '{PQD_OP_SCHED, 8'h40, 8'hB8, 8'h00, 32'h0000_0020};
      rows[14] = '{PQD_OP_SCHED, 8'h40, 8'hBC, 8'h00, 32'h0000_0020};
      rows[15] = '{PQD_OP_DISP, 8'h40, 8'h00, 8'hBC, 32'h0000_0020};
      rows[16] = '{PQD_OP_DISP, 8'h40, 8'h00, 8'hB8, 32'h0000_0020};
      rows[17] = '{PQD_OP_DISP, 8'h40, 8'h00, 8'hBC, 32'h0000_0020};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      cmp({30'h0, busy, mem_req}, 32'h0); // outputs quiet after reset
      cmp(cur_pcb, 32'h0); // bound process cleared by reset
      // fifo port at 10, dispatch priority port at 40 with queue-state 0
      i_mem.mem[8'h40] = 32'h0001_0000;
      i_mem.mem[8'hAA] = 32'h3;
      i_mem.mem[8'hAE] = 32'h14;
      i_mem.mem[8'hB2] = 32'h14;
      i_mem.mem[8'hB6] = 32'h1F;
      i_mem.mem[8'hBA] = 32'h5;
      i_mem.mem[8'hBE] = 32'h5;
      for (k = 0; k < 8; k++) begin
         i_mem.mem[8'hA3 + 4 * k] = 32'h40;
      end
      // table of queue operations
      for (k = 0; k < 18; k++) begin
         start(rows[k].op, rows[k].port, rows[k].msg);
         wait_idle();
         if (rows[k].op == PQD_OP_RECV || rows[k].op == PQD_OP_DISP) begin
            apb(1'b0, PQD_A_RESULT, 32'h0);
            cmp(rdat, {24'h0, rows[k].res});
         end
         if (rows[k].op == PQD_OP_DISP) begin
            cmp(cur_pcb, {24'h0, rows[k].res});
            apb(1'b0, PQD_A_CUR, 32'h0);
            cmp(rdat, {24'h0, rows[k].res});
         end
         // status: done set, empty only when a receive or dispatch found nothing
         e_empty = (rows[k].op == PQD_OP_RECV || rows[k].op == PQD_OP_DISP) &&
            (rows[k].res == 8'h00);
         apb(1'b0, PQD_A_STATUS, 32'h0);
         cmp(rdat, {29'h0, 1'b1, e_empty, 1'b0});
         cmp(i_mem.mem[rows[k].port + 8'h1], rows[k].w1);
         cmp({31'h0, i_mem.mem[rows[k].port][0]}, 32'h0);
         $display("row %0d done", k);
      end
      // dispatch port word0 kept whole through every lock and unlock
      cmp(i_mem.mem[8'h40], 32'h0001_0000);
      // unmapped register answers with an error
      apb(1'b0, 8'h1C, 32'h0);
      cmp({31'h0, serr}, 32'h1);
      $display("unmapped access done");
      // queue record kept by the engine
      start(PQD_OP_SEND, 8'h10, 8'hA0);
      wait_idle();
      start(PQD_OP_SEND, 8'h10, 8'hA4);
      wait_idle();
      cmp(i_mem.mem[8'hA0], 32'hA4);
      cmp(i_mem.mem[8'hA1], 32'h10);
      cmp(i_mem.mem[8'h12], 32'hA4);
      $display("queue record done");
      // port held by another processor, slow memory: engine must spin
      lat <= 4'h3;
      i_mem.mem[8'h10] = 32'h1;
      start(PQD_OP_RECV, 8'h10, 8'h00);
      repeat (40) @(posedge pclk);
      #1;
      cmp({31'h0, busy}, 32'h1);
      i_mem.mem[8'h10] = 32'h0;
      wait_idle();
      apb(1'b0, PQD_A_RESULT, 32'h0);
      cmp(rdat, 32'hA0);
      cmp(i_mem.mem[8'h10], 32'h0);
      cmp(i_mem.mem[8'hA1], 32'h0);
      $display("lock contention done");
      // reset while a receive is under way: all outputs fall back to zero
      start(PQD_OP_RECV, 8'h10, 8'h00);
      repeat (6) @(posedge pclk);
      #1;
      cmp({31'h0, busy}, 32'h1);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      cmp({30'h0, busy, mem_req}, 32'h0); // outputs quiet after reset
      cmp(cur_pcb, 32'h0); // bound process cleared by reset
      apb(1'b0, PQD_A_RESULT, 32'h0);
      cmp(rdat, 32'h0); // result cleared by reset
      $display("mid-run reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
